// File: common/flt_map.svh
// constants for the fastlock timeout control block
`ifndef FLT_MAP_SVH
`define FLT_MAP_SVH
`define FLT_WORD_W 22
`define FLT_ADDR_LSB 0
`define FLT_ADDR_MSB 1
`define FLT_ADDR_TIMEOUT 2'h2
`define FLT_CNT_LSB 2
`define FLT_CNT_MSB 13
`define FLT_SEL_MSB_BIT 14
`define FLT_PAD_LSB 15
`define FLT_PAD_MSB 21
`define FLT_CNT_W 12
`define FLT_CODE_TRI 12'h000
`define FLT_CODE_MAN 12'h001
`define FLT_CODE_LOW 12'h002
`define FLT_CODE_HIGH 12'h003
`define FLT_CODE_MIN 12'h004
`define FLT_CNT_RESET 12'h000
`define FLT_SEL_W 3
`define FLT_SEL_RSVD 3'h7
`endif

// File: common/flt_pkg.sv
// types for the fastlock timeout control block
package flt_pkg;
	// fastlock mode decoded from the timeout word
	typedef enum logic [2:0] {
		FLT_OFF,
		FLT_MANUAL,
		FLT_FORCE_LOW,
		FLT_FORCE_HIGH,
		FLT_TIMED,
		FLT_EXPIRED
	} flt_mode_t;
endpackage

// File: logic/flt_fastlock_timeout.sv
// fastlock timeout control: pin state, charge pump gain, output select msb
//
// Contract
// RULE1: zero: pin released, gain from normal bit
// RULE2: one: pin low, gain forced 4x
// RULE3: two: pin low, gain from normal bit
// RULE4: three: pin high, gain from normal bit
// RULE5: four upward: timed fastlock over pd events
// RULE6: timed: 4x until count reaches zero
// RULE7: timeout value is word bits 13:2
// RULE8: word bit 14 is select msb
// RULE9: gain bit clear 1x, set 4x; after expiry the code gives 1x whatever the bit
// RULE10: three select bits pick output source
// RULE11: controller sends address 10, zero padding
// RULE12: load on latch, decrement per event, release
`timescale 1ns/10ps
`default_nettype none
`include "flt_map.svh"
module flt_fastlock_timeout #(
	parameter int CNT_W = `FLT_CNT_W // timeout counter width
) (
	input wire logic clk_sys_i, // system clock, 200 MHz
	input wire logic arst_n_i, // async reset, active low
	input wire logic [`FLT_WORD_W-1:0] word_i, // latched programming word
	input wire logic word_load_i, // one-cycle latch strobe
	input wire logic pd_event_i, // phase detector event strobe
	input wire logic gain_select_i, // normal charge pump gain bit
	input wire logic [1:0] sel_low_i, // low two output select bits
	output logic fastlock_switch_pin_o, // pin output level
	output logic fastlock_switch_pin_oe_o, // pin drive enable
	output logic charge_pump_4x_o, // 1: 4x current, 0: 1x
	output logic [`FLT_SEL_W-1:0] output_select_o, // full select code
	output logic output_select_rsvd_o, // reserved code selected
	output logic fastlock_active_o, // timed fastlock running
	output var flt_pkg::flt_mode_t mode_o // current mode
);
	import flt_pkg::*;

	// held state
	// mode and count change only on an accepted word or an event
	logic [CNT_W-1:0] fastlock_timeout_count; // remaining events
	logic output_select_msb; // select msb from word
	flt_mode_t mode; // current mode
	logic pd_sync1; // pd event first stage
	logic pd_sync2; // pd event second stage
	logic pd_prev; // for edge detect

	// decode of incoming word
	wire addr_hit = word_i[`FLT_ADDR_MSB:`FLT_ADDR_LSB]
		== `FLT_ADDR_TIMEOUT; // RULE11
	wire take_word = word_load_i && addr_hit; // timeout word latched
	wire [CNT_W-1:0] new_count =
		CNT_W'(word_i[`FLT_CNT_MSB:`FLT_CNT_LSB]); // RULE7
	wire new_sel_msb = word_i[`FLT_SEL_MSB_BIT]; // RULE8
	wire pd_tick = pd_sync2 && !pd_prev; // one per event
	wire cnt_last = fastlock_timeout_count == CNT_W'(1); // final event

	// map value to mode
	function automatic flt_mode_t decode_mode(input logic [CNT_W-1:0] v);
		if (v == CNT_W'(`FLT_CODE_TRI)) begin
			decode_mode = FLT_OFF; // RULE1
		end else if (v == CNT_W'(`FLT_CODE_MAN)) begin
			decode_mode = FLT_MANUAL; // RULE2
		end else if (v == CNT_W'(`FLT_CODE_LOW)) begin
			decode_mode = FLT_FORCE_LOW; // RULE3
		end else if (v == CNT_W'(`FLT_CODE_HIGH)) begin
			decode_mode = FLT_FORCE_HIGH; // RULE4
		end else begin
			decode_mode = FLT_TIMED; // RULE5
		end
	endfunction

	// next state
	// a word and an event in one cycle: the word wins, the event is lost
	flt_mode_t next_mode;
	logic [CNT_W-1:0] next_count;
	always_comb begin
		next_mode = mode;
		next_count = fastlock_timeout_count;
		if (take_word) begin
			next_mode = decode_mode(new_count); // RULE12
			next_count = new_count; // RULE12
		end else begin
			case (mode)
				FLT_TIMED: begin
					if (pd_tick) begin
						next_count = fastlock_timeout_count - CNT_W'(1); // RULE12
						if (cnt_last) begin
							next_mode = FLT_EXPIRED; // RULE6
						end
					end
				end
				default: begin
					next_mode = mode; // static modes hold
				end
			endcase
		end
	end

	// pd event synchroniser
	// only the second stage feeds logic; the first may be metastable
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pd_sync1 <= 1'b0;
			pd_sync2 <= 1'b0;
			pd_prev <= 1'b0;
		end else begin
			pd_sync1 <= pd_event_i;
			pd_sync2 <= pd_sync1;
			pd_prev <= pd_sync2;
		end
	end

	// state registers
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode <= FLT_OFF;
			fastlock_timeout_count <= CNT_W'(`FLT_CNT_RESET);
			output_select_msb <= 1'b0;
		end else begin
			mode <= next_mode;
			fastlock_timeout_count <= next_count;
			if (take_word) begin
				output_select_msb <= new_sel_msb; // RULE8
			end
		end
	end

	// output decode
	wire pin_oe = (mode == FLT_MANUAL) || (mode == FLT_FORCE_LOW)
		|| (mode == FLT_FORCE_HIGH) || (mode == FLT_TIMED); // RULE1
	wire pin_lvl = (mode == FLT_FORCE_HIGH); // RULE4
	// expiry drops to 1x whatever the normal gain bit says
	wire cp_4x = (mode == FLT_MANUAL) || (mode == FLT_TIMED)
		|| (gain_select_i
		&& (mode != FLT_EXPIRED)); // RULE6 RULE9

	// registered outputs
	// every output is a flop, so each one decoded from mode lags mode by one edge
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fastlock_switch_pin_o <= 1'b0;
			fastlock_switch_pin_oe_o <= 1'b0;
			charge_pump_4x_o <= 1'b0;
			output_select_o <= '0;
			output_select_rsvd_o <= 1'b0;
			fastlock_active_o <= 1'b0;
			mode_o <= FLT_OFF;
		end else begin
			fastlock_switch_pin_o <= pin_lvl; // RULE2 RULE3
			fastlock_switch_pin_oe_o <= pin_oe; // RULE1
			charge_pump_4x_o <= cp_4x; // RULE9
			output_select_o <= {output_select_msb, sel_low_i}; // RULE10
			output_select_rsvd_o <=
				{output_select_msb, sel_low_i} == `FLT_SEL_RSVD; // RULE10
			fastlock_active_o <= (mode == FLT_TIMED); // RULE5
			mode_o <= mode;
		end
	end

	// assertions: outputs are registered, so each looks one edge later, except a_sel_msb (two edges) and a_rsvd_flag (same edge)
	// fastlock off: pin released
	a_zero_releases_pin: assert property (@(posedge clk_sys_i) // RULE1
		disable iff (!arst_n_i) mode == FLT_OFF |=> !fastlock_switch_pin_oe_o)
		else $error("pin driven while fastlock off");
	// fastlock off: gain from the normal bit
	a_off_gain_follows: assert property (@(posedge clk_sys_i) // RULE9
		disable iff (!arst_n_i) mode == FLT_OFF
		|=> charge_pump_4x_o == $past(gain_select_i))
		else $error("gain wrong while fastlock off");
	// manual fastlock: pin driven low, gain forced to 4x
	a_manual_forces_gain: assert property (@(posedge clk_sys_i) // RULE2
		disable iff (!arst_n_i) mode == FLT_MANUAL
		|=> charge_pump_4x_o && fastlock_switch_pin_oe_o
		&& !fastlock_switch_pin_o)
		else $error("manual mode output wrong");
	// forced low: pin driven low, gain from the normal bit
	a_low_follows_gain: assert property (@(posedge clk_sys_i) // RULE3
		disable iff (!arst_n_i) mode == FLT_FORCE_LOW
		|=> charge_pump_4x_o == $past(gain_select_i)
		&& fastlock_switch_pin_oe_o && !fastlock_switch_pin_o)
		else $error("force low mode output wrong");
	// forced high: pin driven high
	a_high_drives_pin: assert property (@(posedge clk_sys_i) // RULE4
		disable iff (!arst_n_i) mode == FLT_FORCE_HIGH
		|=> fastlock_switch_pin_o && fastlock_switch_pin_oe_o)
		else $error("force high mode output wrong");
	// values of four upward start a timed fastlock
	a_timed_load: assert property (@(posedge clk_sys_i) // RULE5
		disable iff (!arst_n_i)
		take_word && new_count >= CNT_W'(`FLT_CODE_MIN)
		|=> mode == FLT_TIMED ##1 fastlock_active_o)
		else $error("timed fastlock not started");
	// timed fastlock: pin driven low, gain held at 4x
	a_timed_holds_gain: assert property (@(posedge clk_sys_i) // RULE6
		disable iff (!arst_n_i) mode == FLT_TIMED
		|=> charge_pump_4x_o && fastlock_switch_pin_oe_o
		&& !fastlock_switch_pin_o)
		else $error("timed fastlock output wrong");
	// last event ends the timed fastlock
	a_timed_expiry: assert property (@(posedge clk_sys_i) // RULE6
		disable iff (!arst_n_i) mode == FLT_TIMED && cnt_last && pd_tick
		&& !take_word |=> mode == FLT_EXPIRED ##1 !fastlock_active_o)
		else $error("timed fastlock did not expire");
	// after expiry: pin released, gain back to 1x
	a_expired_drops: assert property (@(posedge clk_sys_i) // RULE6 RULE12
		disable iff (!arst_n_i) mode == FLT_EXPIRED
		|=> !charge_pump_4x_o && !fastlock_switch_pin_oe_o)
		else $error("expired fastlock output wrong");
	// value field lands in the counter
	a_word_fields: assert property (@(posedge clk_sys_i) // RULE7
		disable iff (!arst_n_i) take_word
		|=> fastlock_timeout_count == $past(new_count))
		else $error("timeout value not loaded");
	// select msb reaches the select code two edges on
	a_sel_msb: assert property (@(posedge clk_sys_i) // RULE8
		disable iff (!arst_n_i) take_word
		|=> ##1 output_select_o[2] == $past(word_i[`FLT_SEL_MSB_BIT], 2))
		else $error("select msb not taken");
	// one step down per event
	a_count_step: assert property (@(posedge clk_sys_i) // RULE12
		disable iff (!arst_n_i) mode == FLT_TIMED && pd_tick && !take_word
		|=> fastlock_timeout_count
		== $past(fastlock_timeout_count) - CNT_W'(1))
		else $error("count did not step");
	// reserved select code is flagged, and only that code
	a_rsvd_flag: assert property (@(posedge clk_sys_i) // RULE10
		disable iff (!arst_n_i)
		output_select_rsvd_o == (output_select_o == `FLT_SEL_RSVD))
		else $error("reserved select flag wrong");
endmodule
`default_nettype wire

// File: sim/flt_pd_source.sv
// phase detector event source model for the fastlock bench
`timescale 1ns/10ps
`default_nettype none
module flt_pd_source (
	input wire logic clk_sys_i, // system clock
	input wire logic go_i, // start a burst of events
	input wire logic [3:0] n_i, // events in the burst
	output logic pd_o, // event strobe
	output logic busy_o // burst running
);
	logic [5:0] ph = 6'h0; // four cycles per event
	assign busy_o = ph != 6'h0;
	// two cycles high, two low: each edge is seen by the sync
	assign pd_o = ph[1];
	// phase countdown
	always_ff @(posedge clk_sys_i) begin
		if (go_i) ph <= {n_i, 2'h0};
		else if (busy_o) ph <= ph - 6'h1;
	end
endmodule
`default_nettype wire

// File: sim/flt_fastlock_timeout_test.sv
// self-checking bench for the fastlock timeout control
`timescale 1ns/10ps
`default_nettype none
module flt_fastlock_timeout_test;
	import flt_pkg::*;
	logic clk_sys_i = 1'b0, arst_n_i = 1'b0, word_load_i = 1'b0;
	logic gain_select_i = 1'b0, go = 1'b0, pd, busy, pin, oe, cp4x, rsvd, act;
	logic [21:0] word_i = 22'h0; // programming word
	logic [1:0] sel_low_i = 2'h3; // low select bits
	logic [3:0] n = 4'h0; // burst length
	logic [2:0] osel; // select code seen
	flt_mode_t mode; // mode seen
	int mismatches = 0, num_checks = 0, cyc = 0;
	// rows: code, gain, then expected oe, pin, 4x
	logic [5:0] rows [8] = '{6'h00, 6'h09, 6'h15, 6'h1d,
		6'h24, 6'h2d, 6'h36, 6'h3f};
	flt_fastlock_timeout DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.word_i(word_i), .word_load_i(word_load_i), .pd_event_i(pd),
		.gain_select_i(gain_select_i), .sel_low_i(sel_low_i),
		.fastlock_switch_pin_o(pin), .fastlock_switch_pin_oe_o(oe),
		.charge_pump_4x_o(cp4x), .output_select_o(osel),
		.output_select_rsvd_o(rsvd), .fastlock_active_o(act), .mode_o(mode));
	flt_pd_source u_pd (.clk_sys_i(clk_sys_i), .go_i(go), .n_i(n),
		.pd_o(pd), .busy_o(busy));
	always #2.5 clk_sys_i = ~clk_sys_i;
	// hang guard
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [3:0] e,
		input logic [3:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one word with gain bit, outputs settled on return
	task automatic load(input logic [1:0] a, input logic [11:0] v,
		input logic m, input logic g);
		@(posedge clk_sys_i);
		word_i <= {7'h0, m, v, a};
		word_load_i <= 1'b1;
		gain_select_i <= g;
		@(posedge clk_sys_i);
		word_load_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask
	// burst of events, then counting has landed
	task automatic burst(input logic [3:0] v);
		@(posedge clk_sys_i);
		go <= 1'b1;
		n <= v;
		@(posedge clk_sys_i);
		go <= 1'b0;
		repeat (4 * v + 6) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		chk("reset", 4'h0, {oe, cp4x, act, rsvd});
		arst_n_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			load(2'h2, {10'h0, rows[i][5:4]}, 1'b0, rows[i][3]);
			chk("pins", {1'b0, rows[i][2:0]},
				{1'b0, oe, pin, cp4x});
		end
		$display("static codes done");
		load(2'h1, 12'h5, 1'b1, 1'b0);
		chk("ignored", 4'h6, {osel[2], oe, pin, cp4x});
		load(2'h2, 12'h3, 1'b1, 1'b0);
		chk("select", 4'hf, {rsvd, osel});
		$display("select done");
		load(2'h2, 12'h5, 1'b0, 1'b0);
		chk("timed", 4'hd, {act, oe, pin, cp4x});
		burst(4'h4);
		chk("counting", 4'hd, {act, oe, pin, cp4x});
		burst(4'h1);
		chk("expired", 4'h0, {act, oe, pin, cp4x});
		chk("mode", {1'b0, FLT_EXPIRED}, {1'b0, mode});
		load(2'h2, 12'h4, 1'b0, 1'b1);
		burst(4'h3);
		chk("min left", 4'hd, {act, oe, pin, cp4x});
		burst(4'h1);
		chk("min end", 4'h0, {act, oe, pin, cp4x});
		$display("timed done");
		// reset in mid-run during a timed fastlock
		load(2'h2, 12'h6, 1'b1, 1'b1);
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		#1;
		chk("mid reset", 4'h0, {act, oe, pin, cp4x});
		chk("mid mode", {1'b0, FLT_OFF}, {1'b0, mode});
		chk("mid select", 4'h0, {rsvd, osel});
		@(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		load(2'h2, 12'h3, 1'b0, 1'b0);
		chk("after reset", 4'h6, {osel[2], oe, pin, cp4x});
		$display("reset done");
		stop_test();
	end
endmodule
`default_nettype wire
